/* File: hdl/tmrps_map.vh */
// Purpose: constants for the timer prescale, postscale and output block
// Assumes: APB word access, register index times four gives the byte address
// Notes:   bit positions are within the low byte of each register word
//
// Notes on behaviour
// R1: Input prescaler offers sixteen ratios, 1:1 to 1:32768, from a 4-bit field.
// R2: Prescaler count is hidden; cleared on low count write, control write, reset.
// R3: Postscaler divides match or rollover events by 1:1 to 1:16.
// R4: Postscaler count is hidden; cleared on low count write, control write, reset.
// R5: Output toggles on 8-bit match, or on 16-bit rollover in wide mode.
// R6: With postscale above 1:1, output toggles once per selected event count.
// R7: Toggle output is offered to pin routing and other peripherals.
// R8: Output level readable at control zero bit 5, read-only, resets 0.
// R9: Interrupt flag sets on each toggle; with enable set, raises a request.
// R10: Postscale value N sets the flag every N+1 events; 1:1 sets every event.
// R11: Synchronous input mode stops counting during sleep.
// R12: Asynchronous mode keeps counting in sleep; enabled interrupt wakes device.
// R13: Control zero bit 7 enables the timer, resets to 0.
// R14: Control zero bit 4 selects 16-bit counting, resets to 0.
// R15: Control zero bits 3:0 select postscale; value plus one is the divisor.
// R16: Control one bits 7:5 select one of eight clock sources.
// R17: Control one bit 4 set passes input unsynced; clear syncs to instruction clock.
// R18: Control one bits 3:0 hold prescale select; all control bits reset to 0.
// R19: Prescale value N divides by two to the power N.
// R20: Clearing enable freezes prescaler, postscaler and output, no new flags.
`ifndef TMRPS_MAP_VH
`define TMRPS_MAP_VH

`define TMRPS_IDX_CTL0     12'h19E
`define TMRPS_IDX_CTL1     12'h19F
`define TMRPS_ADDR_W       14
`define TMRPS_ADDR_CTL0    14'h0678
`define TMRPS_ADDR_CTL1    14'h067C
`define TMRPS_CTL0_RST     8'h00
`define TMRPS_CTL1_RST     8'h00
`define TMRPS_C0_EN        7
`define TMRPS_C0_OUT       5
`define TMRPS_C0_WIDE      4
`define TMRPS_C1_UNSYNCED_INPUT_SELECT     4
`define TMRPS_PRE_W        15
`define TMRPS_INSTR_DIV    2'h3
`define TMRPS_SRC_PIN      3'h0
`define TMRPS_SRC_PIN_INV  3'h1

`endif

/* File: hdl/tmrps_top.v */
// Purpose: prescaler, postscaler, toggle output and control registers of a timer
// Assumes: all inputs synchronous to CLK; counter core outside supplies match strobes
// Notes:   APB slave answers with one wait state; unmapped addresses give PSLVERR
`timescale 1ns/1ps
`include "tmrps_map.vh"

module tmrps_top #(
	parameter PRE_W = `TMRPS_PRE_W
)(
	CLK,
	RST_N,
	PSEL,
	PENABLE,
	PWRITE,
	PADDR,
	PWDATA,
	PRDATA,
	PREADY,
	PSLVERR,
	CLK_SRC,
	SLEEP,
	COUNT_LOW_WR,
	MATCH_8,
	ROLL_16,
	IRQ_ENABLE,
	IRQ_FLAG_CLR,
	COUNT_TICK,
	TIMER_EN,
	WIDE_MODE,
	TOGGLE_OUT,
	IRQ_FLAG,
	IRQ_REQ,
	WAKE
);
	input  wire                    CLK;
	input  wire                    RST_N;
	input  wire                    PSEL;
	input  wire                    PENABLE;
	input  wire                    PWRITE;
	input  wire [`TMRPS_ADDR_W-1:0] PADDR;
	input  wire [31:0]             PWDATA;
	output reg  [31:0]             PRDATA;
	output reg                     PREADY;
	output reg                     PSLVERR;
	input  wire [7:0]              CLK_SRC;
	input  wire                    SLEEP;
	input  wire                    COUNT_LOW_WR;
	input  wire                    MATCH_8;
	input  wire                    ROLL_16;
	input  wire                    IRQ_ENABLE;
	input  wire                    IRQ_FLAG_CLR;
	output reg                     COUNT_TICK;
	output reg                     TIMER_EN;
	output reg                     WIDE_MODE;
	output reg                     TOGGLE_OUT;
	output reg                     IRQ_FLAG;
	output reg                     IRQ_REQ;
	output reg                     WAKE;

	// Terminal count of the prescaler for a select value: two to the N, minus one
	function [PRE_W-1:0] pre_limit;
		input [3:0] sel;
		reg   [PRE_W:0] one_hot;
		begin
			one_hot   = {{PRE_W{1'b0}}, 1'b1} << sel;
			pre_limit = one_hot[PRE_W-1:0] - {{(PRE_W-1){1'b0}}, 1'b1};
		end
	endfunction

	function is_addr;
		input [`TMRPS_ADDR_W-1:0] a;
		input [`TMRPS_ADDR_W-1:0] b;
		begin
			is_addr = (a == b);
		end
	endfunction

	reg  [7:0]       ctl0_q;
	reg  [7:0]       ctl1_q;
	reg              out_q;
	reg  [PRE_W-1:0] pre_cnt_q;
	reg  [3:0]       post_cnt_q;
	reg  [1:0]       instr_cnt_q;
	reg              src_prev_q;
	reg              pend_q;
	reg              flag_q;

	wire             en        = ctl0_q[`TMRPS_C0_EN];
	wire             wide      = ctl0_q[`TMRPS_C0_WIDE];
	wire [3:0]       post_sel  = ctl0_q[3:0];
	wire [2:0]       src_sel   = ctl1_q[7:5];
	wire             unsynced_input_select_sel = ctl1_q[`TMRPS_C1_UNSYNCED_INPUT_SELECT];
	wire [3:0]       pre_sel   = ctl1_q[3:0];

	wire             apb_setup = PSEL & ~PENABLE;
	wire             apb_done  = PSEL & PENABLE & PREADY;
	wire             hit0      = is_addr(PADDR, `TMRPS_ADDR_CTL0);
	wire             hit1      = is_addr(PADDR, `TMRPS_ADDR_CTL1);
	wire             wr0       = apb_done & PWRITE & hit0;
	wire             wr1       = apb_done & PWRITE & hit1;
	wire             scale_clr = wr0 | wr1 | COUNT_LOW_WR; // R2 R4

	// Source pin true or inverted; index 1 of CLK_SRC is unused, the pin is inverted here
	reg              src_lvl;
	always @*
	begin
		src_lvl = 1'b0;
		case (src_sel)
		3'h0:
		begin
			src_lvl = CLK_SRC[`TMRPS_SRC_PIN]; // R16
		end
		3'h1:
		begin
			src_lvl = ~CLK_SRC[`TMRPS_SRC_PIN]; // R16
		end
		3'h2:
		begin
			src_lvl = CLK_SRC[2]; // R16
		end
		3'h3:
		begin
			src_lvl = CLK_SRC[3]; // R16
		end
		3'h4:
		begin
			src_lvl = CLK_SRC[4]; // R16
		end
		3'h5:
		begin
			src_lvl = CLK_SRC[5]; // R16
		end
		3'h6:
		begin
			src_lvl = CLK_SRC[6]; // R16
		end
		3'h7:
		begin
			src_lvl = CLK_SRC[7]; // R16
		end
		default:
		begin
			src_lvl = 1'b0;
		end
		endcase
	end

	wire             src_rise  = src_lvl & ~src_prev_q;
	wire             instr_pls = (instr_cnt_q == `TMRPS_INSTR_DIV) & ~SLEEP;

	// Synchronous mode only counts on instruction-clock beats, which stop in sleep
	reg              in_evt;
	always @*
	begin
		in_evt = 1'b0;
		if (en)
		begin
			if (unsynced_input_select_sel)
			begin
				in_evt = src_rise; // R17 R12
			end
			else
			begin
				in_evt = (pend_q | src_rise) & instr_pls; // R17 R11
			end
		end
	end

	wire             pre_wrap  = (pre_cnt_q == pre_limit(pre_sel)); // R19
	wire             tick      = in_evt & pre_wrap; // R1
	wire             core_evt  = en & (wide ? ROLL_16 : MATCH_8); // R5 R20
	wire             post_wrap = (post_cnt_q == post_sel); // R10 R15
	wire             toggle    = core_evt & post_wrap & ~scale_clr; // R6 R3

	// Instruction clock: one beat every four system clocks
	always @(posedge CLK)
	begin
		if (!RST_N)
		begin
			instr_cnt_q <= 2'h0;
		end
		else
		begin
			instr_cnt_q <= instr_cnt_q + 2'h1;
		end
	end

	// Edge capture; a pending edge waits for the next instruction beat
	always @(posedge CLK)
	begin
		if (!RST_N)
		begin
			src_prev_q <= 1'b0;
			pend_q     <= 1'b0;
		end
		else
		begin
			src_prev_q <= src_lvl;
			if (!en || unsynced_input_select_sel || scale_clr)
			begin
				pend_q <= 1'b0;
			end
			// Edges seen while asleep are lost, not replayed on wake
			else if (SLEEP)
			begin
				pend_q <= 1'b0; // R11
			end
			else if (instr_pls)
			begin
				pend_q <= 1'b0;
			end
			else if (src_rise)
			begin
				pend_q <= 1'b1;
			end
		end
	end

	always @(posedge CLK)
	begin
		if (!RST_N)
		begin
			pre_cnt_q <= {PRE_W{1'b0}};
		end
		else if (scale_clr)
		begin
			pre_cnt_q <= {PRE_W{1'b0}}; // R2
		end
		else if (in_evt)
		begin
			if (pre_wrap)
			begin
				pre_cnt_q <= {PRE_W{1'b0}};
			end
			else
			begin
				pre_cnt_q <= pre_cnt_q + {{(PRE_W-1){1'b0}}, 1'b1}; // R1
			end
		end
	end

	always @(posedge CLK)
	begin
		if (!RST_N)
		begin
			post_cnt_q <= 4'h0;
		end
		else if (scale_clr)
		begin
			post_cnt_q <= 4'h0; // R4
		end
		else if (core_evt)
		begin
			if (post_wrap)
			begin
				post_cnt_q <= 4'h0;
			end
			else
			begin
				post_cnt_q <= post_cnt_q + 4'h1; // R3
			end
		end
	end

	always @(posedge CLK)
	begin
		if (!RST_N)
		begin
			out_q <= 1'b0;
		end
		else if (toggle)
		begin
			out_q <= ~out_q; // R5 R6
		end
	end

	// Set wins over a clear arriving in the same cycle
	always @(posedge CLK)
	begin
		if (!RST_N)
		begin
			flag_q <= 1'b0;
		end
		else if (toggle)
		begin
			flag_q <= 1'b1; // R9 R10
		end
		else if (IRQ_FLAG_CLR)
		begin
			flag_q <= 1'b0;
		end
	end

	// Control registers; the output bit and bit 6 are not stored
	always @(posedge CLK)
	begin
		if (!RST_N)
		begin
			ctl0_q <= `TMRPS_CTL0_RST; // R18
			ctl1_q <= `TMRPS_CTL1_RST; // R18
		end
		else
		begin
			if (wr0)
			begin
				ctl0_q <= {PWDATA[7], 2'b00, PWDATA[4:0]}; // R13 R14 R15
			end
			if (wr1)
			begin
				ctl1_q <= PWDATA[7:0]; // R16 R17 R18
			end
		end
	end

	// APB: one wait state, so read data and writes settle on one edge
	always @(posedge CLK)
	begin
		if (!RST_N)
		begin
			PREADY  <= 1'b0;
			PSLVERR <= 1'b0;
			PRDATA  <= 32'h00000000;
		end
		else if (apb_done || apb_setup || !PSEL)
		begin
			PREADY  <= 1'b0;
			PSLVERR <= 1'b0;
			PRDATA  <= 32'h00000000;
		end
		else
		begin
			PREADY  <= 1'b1;
			PSLVERR <= ~(hit0 | hit1);
			if (!PWRITE && hit0)
			begin
				PRDATA <= {24'h000000, en, 1'b0, out_q, ctl0_q[4:0]}; // R8
			end
			else if (!PWRITE && hit1)
			begin
				PRDATA <= {24'h000000, ctl1_q};
			end
			else
			begin
				PRDATA <= 32'h00000000;
			end
		end
	end

	// Output stage: all ports from flops
	always @(posedge CLK)
	begin
		if (!RST_N)
		begin
			COUNT_TICK <= 1'b0;
			TIMER_EN   <= 1'b0;
			WIDE_MODE  <= 1'b0;
			TOGGLE_OUT <= 1'b0;
			IRQ_FLAG   <= 1'b0;
			IRQ_REQ    <= 1'b0;
			WAKE       <= 1'b0;
		end
		else
		begin
			COUNT_TICK <= tick & ~scale_clr; // R1
			TIMER_EN   <= en; // R13
			WIDE_MODE  <= wide; // R14
			TOGGLE_OUT <= out_q; // R7
			IRQ_FLAG   <= flag_q; // R9
			IRQ_REQ    <= flag_q & IRQ_ENABLE; // R9
			WAKE       <= flag_q & IRQ_ENABLE & SLEEP & unsynced_input_select_sel; // R12
		end
	end

endmodule // tmrps_top

/* File: verif/tmrps_asserts.sv */
// Purpose: port checks for the timer scaler block
// Assumes: one clock, reset active low
// Notes: bound to the top module by port name
`timescale 1ns/1ps
module tmrps_chk (
	input logic        CLK,
	input logic        RST_N,
	input logic        PSEL,
	input logic        PENABLE,
	input logic [31:0] PRDATA,
	input logic        PREADY,
	input logic        PSLVERR,
	input logic        IRQ_ENABLE,
	input logic        TIMER_EN,
	input logic        TOGGLE_OUT,
	input logic        IRQ_FLAG,
	input logic        IRQ_REQ,
	input logic        WAKE
);
	default clocking @(posedge CLK);
	endclocking
	default disable iff (!RST_N);
	a_ready_access: assert property (PREADY |-> PSEL && PENABLE)
		else $error("ready outside access");
	a_ready_pulse: assert property (PREADY |=> !PREADY)
		else $error("ready held");
	a_answer_bound: assert property (PSEL && !PENABLE |-> ##[1:3] PREADY)
		else $error("no answer");
	a_idle_rdata: assert property (!PREADY |-> PRDATA == 32'h0)
		else $error("read data off");
	a_err_ready: assert property (PSLVERR |-> PREADY)
		else $error("error alone");
	a_toggle_flag: assert property (TOGGLE_OUT != $past(TOGGLE_OUT) |-> IRQ_FLAG)
		else $error("toggle without flag");
	a_irq_req: assert property (IRQ_REQ |-> IRQ_FLAG && $past(IRQ_ENABLE))
		else $error("request without cause");
	a_wake_req: assert property (WAKE |-> IRQ_REQ)
		else $error("wake without request");
	// Three cycles covers the enable register lag
	a_hold_off: assert property (!TIMER_EN [*3] |-> $stable(TOGGLE_OUT))
		else $error("toggle while off");
endmodule // tmrps_chk

bind tmrps_top tmrps_chk u_chk (
	.CLK        (CLK),
	.RST_N      (RST_N),
	.PSEL       (PSEL),
	.PENABLE    (PENABLE),
	.PRDATA     (PRDATA),
	.PREADY     (PREADY),
	.PSLVERR    (PSLVERR),
	.IRQ_ENABLE (IRQ_ENABLE),
	.TIMER_EN   (TIMER_EN),
	.TOGGLE_OUT (TOGGLE_OUT),
	.IRQ_FLAG   (IRQ_FLAG),
	.IRQ_REQ    (IRQ_REQ),
	.WAKE       (WAKE)
);

/* File: verif/tmrps_tb.sv */
// Purpose: random and corner tests of the timer scaler block
// Assumes: core events are single-cycle pulses
// Notes: expected values come from field values only
`timescale 1ns/1ps
`include "tmrps_map.vh"
`define CK(a, b) begin n_tests++; if ((a) !== (b)) begin error_cnt++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module tmrps_tb_top;
	logic        CLK = 0, RST_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, SLEEP = 0;
	logic        COUNT_LOW_WR = 0, MATCH_8 = 0, ROLL_16 = 0, IRQ_ENABLE = 0, IRQ_FLAG_CLR = 0;
	logic [13:0] PADDR = 0;
	logic [31:0] PWDATA = 0, rd;
	logic [7:0]  CLK_SRC = 0, v;
	logic [3:0]  ps [4] = '{4'h0, 4'h1, 4'hF, 4'h0};
	logic        er, tg = 0;
	wire  [31:0] PRDATA;
	wire         PREADY, PSLVERR, COUNT_TICK, TIMER_EN, WIDE_MODE;
	wire         TOGGLE_OUT, IRQ_FLAG, IRQ_REQ, WAKE;
	int          error_cnt = 0, n_tests = 0, ticks = 0, tn = 0;
	always #20 CLK = ~CLK;
	always @(posedge CLK)
		if (COUNT_TICK === 1'b1)
			ticks <= ticks + 1;
	tmrps_top dut (
		.CLK          (CLK),
		.RST_N        (RST_N),
		.PSEL         (PSEL),
		.PENABLE      (PENABLE),
		.PWRITE       (PWRITE),
		.PADDR        (PADDR),
		.PWDATA       (PWDATA),
		.PRDATA       (PRDATA),
		.PREADY       (PREADY),
		.PSLVERR      (PSLVERR),
		.CLK_SRC      (CLK_SRC),
		.SLEEP        (SLEEP),
		.COUNT_LOW_WR (COUNT_LOW_WR),
		.MATCH_8      (MATCH_8),
		.ROLL_16      (ROLL_16),
		.IRQ_ENABLE   (IRQ_ENABLE),
		.IRQ_FLAG_CLR (IRQ_FLAG_CLR),
		.COUNT_TICK   (COUNT_TICK),
		.TIMER_EN     (TIMER_EN),
		.WIDE_MODE    (WIDE_MODE),
		.TOGGLE_OUT   (TOGGLE_OUT),
		.IRQ_FLAG     (IRQ_FLAG),
		.IRQ_REQ      (IRQ_REQ),
		.WAKE         (WAKE)
	);
	task automatic stop_test;
		$display("comparisons=%0d mismatches=%0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [13:0] a, input logic [7:0] d);
		int k;
		@(posedge CLK);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= {24'h0, d};
		@(posedge CLK);
		PENABLE <= 1'b1;
		k = 0;
		do
		begin
			@(posedge CLK);
			k++;
		end
		while (PREADY !== 1'b1 && k < 20);
		if (k >= 20)
		begin
			error_cnt++;
			stop_test();
		end
		rd = PRDATA;
		er = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask
	// Mask bits: 1 match, 2 rollover, 4 flag clear, 8 low count write
	task automatic ev(input logic [3:0] m);
		@(posedge CLK);
		{COUNT_LOW_WR, IRQ_FLAG_CLR, ROLL_16, MATCH_8} <= m;
		@(posedge CLK);
		{COUNT_LOW_WR, IRQ_FLAG_CLR, ROLL_16, MATCH_8} <= 4'h0;
		@(posedge CLK);
	endtask
	// Source held high and low long enough for the instruction beat
	task automatic src(int c);
		repeat (c)
		begin
			CLK_SRC[0] <= 1'b1;
			repeat (8) @(posedge CLK);
			CLK_SRC[0] <= 1'b0;
			repeat (8) @(posedge CLK);
		end
	endtask
	task automatic fin;
		tn++;
		$display("test %0d done", tn);
	endtask
	initial
	begin
		void'($urandom(32'h1E5F50BA));
		ps[3] = $urandom;
		repeat (4) @(posedge CLK);
		RST_N <= 1'b1;
		apb(0, `TMRPS_ADDR_CTL0, 8'h0);
		`CK(rd, 32'h0)
		apb(0, `TMRPS_ADDR_CTL1, 8'h0);
		`CK(rd, 32'h0)
		fin();
		repeat (8)
		begin
			v = $urandom;
			apb(1, `TMRPS_ADDR_CTL1, v);
			apb(0, `TMRPS_ADDR_CTL1, 8'h0);
			`CK(rd, {24'h0, v})
			v = $urandom;
			apb(1, `TMRPS_ADDR_CTL0, v);
			apb(0, `TMRPS_ADDR_CTL0, 8'h0);
			`CK(rd, {24'h0, v[7], 1'b0, tg, v[4:0]})
		end
		apb(1, 14'h0680, 8'hFF);
		`CK(er, 1'b1)
		fin();
		foreach (ps[i])
		begin
			apb(1, `TMRPS_ADDR_CTL1, 8'h10);
			apb(1, `TMRPS_ADDR_CTL0, {4'h8, ps[i]});
			IRQ_ENABLE <= ps[i][0];
			ev(4'h4);
			repeat (ps[i])
			begin
				ev(4'h2);
				ev(4'h1);
			end
			`CK(TOGGLE_OUT, tg)
			`CK(IRQ_FLAG, 1'b0)
			ev(4'h1);
			repeat (2) @(posedge CLK);
			tg = ~tg;
			`CK(TOGGLE_OUT, tg)
			`CK(IRQ_FLAG, 1'b1)
			`CK(IRQ_REQ, ps[i][0])
			apb(0, `TMRPS_ADDR_CTL0, 8'h0);
			`CK(rd[5], tg)
		end
		fin();
		apb(1, `TMRPS_ADDR_CTL0, 8'h90);
		SLEEP <= 1'b1;
		IRQ_ENABLE <= 1'b1;
		ev(4'h1);
		repeat (2) @(posedge CLK);
		`CK(TOGGLE_OUT, tg)
		ev(4'h2);
		repeat (2) @(posedge CLK);
		tg = ~tg;
		`CK(TOGGLE_OUT, tg)
		`CK(WAKE, 1'b1)
		SLEEP <= 1'b0;
		apb(1, `TMRPS_ADDR_CTL0, 8'h00);
		ev(4'h2);
		repeat (2) @(posedge CLK);
		`CK(TOGGLE_OUT, tg)
		apb(1, `TMRPS_ADDR_CTL0, 8'h81);
		repeat (2) @(posedge CLK);
		`CK(TIMER_EN, 1'b1)
		`CK(WIDE_MODE, 1'b0)
		ev(4'h1);
		ev(4'h8);
		ev(4'h1);
		repeat (2) @(posedge CLK);
		`CK(TOGGLE_OUT, tg)
		ev(4'h4);
		repeat (2) @(posedge CLK);
		`CK(IRQ_FLAG, 1'b0)
		ev(4'h5);
		repeat (2) @(posedge CLK);
		tg = ~tg;
		`CK(TOGGLE_OUT, tg)
		`CK(IRQ_FLAG, 1'b1)
		fin();
		for (int n = 0; n < 4; n++)
		begin
			apb(1, `TMRPS_ADDR_CTL1, {4'h1, n[3:0]});
			apb(1, `TMRPS_ADDR_CTL0, 8'h80);
			ticks = 0;
			src((2 << n) - 1);
			`CK(ticks, 1)
		end
		apb(1, `TMRPS_ADDR_CTL1, 8'h11);
		ticks = 0;
		src(1);
		ev(4'h8);
		src(1);
		`CK(ticks, 0)
		src(1);
		`CK(ticks, 1)
		apb(1, `TMRPS_ADDR_CTL1, 8'h00);
		SLEEP <= 1'b1;
		ticks = 0;
		src(3);
		`CK(ticks, 0)
		SLEEP <= 1'b0;
		src(3);
		`CK(ticks, 3)
		fin();
		stop_test();
	end
endmodule // tmrps_tb_top
